// [resonator_tune_sequencer.sv]
`timescale 1ns/1ps
// Behaviour
// - Leaving ADC standby with tank flag set starts tank tuning.
// - Tank flag self-clears when tank tuning ends, well under 6 ms.
// - Tank code readable: 3-bit coarse at 0x1D, 6-bit fine at 0x1E.
// - Leaving ADC standby with filter flag set starts filter tuning.
// - Filter flag self-clears at the end; code readable at 0x1F.
// - With both flags set, tank tunes first, then the filter.
// - While tuning, sample port gives no data; the clock output keeps running.
// - No clock or sync held low stalls tuning; no resonance stalls tank tuning only; flags stay.
// - Clock output runs only when ADC is active and not tristated.
// - Stored codes survive entering and leaving standby.
// - Tank code set by tuning or by host writes.
// - Discrete-time stage tracks the clock; it needs no tuning.
// - Standby register: eight section bits, reset to all in standby.
// - Tune control: bit 1 tank flag, bit 0 filter flag, reset zero.
module resonator_tune_sequencer #(
	parameter int unsigned STEP_SETTLE_CYC = tune_pkg::STEP_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Serial control port
	input  wire logic       serial_clk,
	input  wire logic       serial_enable_n,
	input  wire logic       serial_data_in,
	output logic            serial_data_out,
	output logic            serial_data_out_oe,
	// Resonator sense from the analog side
	input  wire logic       tank_freq_high,
	input  wire logic       filter_freq_high,
	input  wire logic       tank_osc_ok,
	input  wire logic       sync_input_n,
	// Analog controls
	output logic [7:0]      section_standby_mask,
	output logic [8:0]      tank_cap_code,
	output logic [7:0]      filter_cap_code,
	output logic            dac_manual_en,
	output logic [7:0]      dac_manual_value,
	output logic [7:0]      converter_test_bits,
	output logic            tune_busy,
	// Clock output pin and serial sample port gate
	output logic            clock_output_pin,
	output logic            clock_output_pin_oe,
	output logic            sample_port_enable
);

	localparam int TW = tune_pkg::TANK_W;
	localparam int FW = tune_pkg::FILTER_W;
	localparam int TB = tune_pkg::TANK_FLAG_BIT;
	localparam int FB = tune_pkg::FILTER_FLAG_BIT;
	localparam int AB = tune_pkg::ADC_SECTION_STANDBY_MASK_BIT;
	localparam logic [15:0] SETTLE_LAST = 16'(STEP_SETTLE_CYC - 1);

	logic [6:0]  link_addr;
	logic        link_rd;
	logic [7:0]  link_wdata;
	logic        addr_tgl;
	logic        data_tgl;
	logic [5:0]  sync_q;
	logic [1:0]  tgl_prev_q;
	logic        addr_ev;
	logic        wr_ev;
	logic [7:0]  rd_mux;
	logic [7:0]  rd_data_q;
	logic [7:0]  section_standby_mask_q;
	logic [7:0]  clock_output_pin_ctrl_q;
	logic [7:0]  dac_ctrl_q;
	logic [7:0]  test_q;
	logic [1:0]  flags_q;
	logic [TW-1:0] tank_code_q;
	logic [FW-1:0] filter_code_q;
	logic        adc_section_standby_mask_prev_q;
	logic        start_ev;
	logic        start_tank;
	logic        start_filter;
	tune_pkg::tune_state_t state_q;
	logic [3:0]  idx_q;
	logic [15:0] settle_q;
	logic        halted;
	logic        step_done;
	logic        tank_done;
	logic        filter_done;
	logic        wr_tune;
	logic        clock_output_pin_en;
	logic        div_q;

	// Shift logic on the serial clock.
	serial_ctrl_link u_link (
		.sclk       (serial_clk),
		.cs_n       (serial_enable_n),
		.sdi        (serial_data_in),
		.sdo        (serial_data_out),
		.sdo_oe     (serial_data_out_oe),
		.rst_b      (rst_b),
		.addr_q     (link_addr),
		.rd_q       (link_rd),
		.wdata_q    (link_wdata),
		.addr_tgl_q (addr_tgl),
		.data_tgl_q (data_tgl),
		.rd_data    (rd_data_q)
	);

	// Toggles and asynchronous sense levels enter the clock domain.
	flop_sync #(.W(6)) u_sync (
		.clk   (mclk),
		.rst_b (rst_b),
		.d     ({sync_input_n, tank_osc_ok, filter_freq_high,
		         tank_freq_high, data_tgl, addr_tgl}),
		.q     (sync_q)
	);

	// A change of a synchronised toggle marks a new address or data word.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tgl_prev_q <= 2'h0;
		end else begin
			tgl_prev_q <= sync_q[1:0];
		end
	end

	assign addr_ev = sync_q[0] ^ tgl_prev_q[0];
	assign wr_ev   = (sync_q[1] ^ tgl_prev_q[1]) & ~link_rd;
	assign wr_tune = wr_ev && link_addr == tune_pkg::ADDR_TUNE;

	// Read decode; unmapped addresses and unused bits read as zero.
	always_comb begin
		rd_mux = 8'h00;
		case (link_addr)
		tune_pkg::ADDR_STANDBY:  rd_mux = section_standby_mask_q;
		tune_pkg::ADDR_CLOCK_OUTPUT_PIN:   rd_mux = clock_output_pin_ctrl_q;
		tune_pkg::ADDR_TUNE:     rd_mux = {6'h00, flags_q};
		tune_pkg::ADDR_COARSE:   rd_mux = {5'h00, tank_code_q[TW-1:6]};
		tune_pkg::ADDR_FINE:     rd_mux = {2'h0, tank_code_q[5:0]};
		tune_pkg::ADDR_FILTER:   rd_mux = filter_code_q;
		tune_pkg::ADDR_DAC_CTRL: rd_mux = dac_ctrl_q;
		tune_pkg::ADDR_DAC_VAL:  rd_mux = dac_manual_value;
		tune_pkg::ADDR_TEST:     rd_mux = test_q;
		default:                 rd_mux = 8'h00;
		endcase
	end

	// Read data is caught once the address word has crossed over.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q <= 8'h00;
		end else if (addr_ev) begin
			rd_data_q <= rd_mux;
		end
	end

	// Plain configuration registers written by the host.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			section_standby_mask_q           <= tune_pkg::STANDBY_RST;
			clock_output_pin_ctrl_q    <= tune_pkg::ZERO_RST;
			dac_ctrl_q       <= tune_pkg::ZERO_RST;
			dac_manual_value <= tune_pkg::ZERO_RST;
			test_q           <= tune_pkg::ZERO_RST;
		end else if (wr_ev) begin
			case (link_addr)
			tune_pkg::ADDR_STANDBY:  section_standby_mask_q <= link_wdata;
			tune_pkg::ADDR_CLOCK_OUTPUT_PIN:   clock_output_pin_ctrl_q <= link_wdata;
			tune_pkg::ADDR_DAC_CTRL: dac_ctrl_q <= link_wdata;
			tune_pkg::ADDR_DAC_VAL:  dac_manual_value <= link_wdata;
			tune_pkg::ADDR_TEST:     test_q <= link_wdata;
			default:                 ;
			endcase
		end
	end

	assign section_standby_mask = section_standby_mask_q;
	assign dac_manual_en        = dac_ctrl_q[0];
	assign converter_test_bits  = test_q;
	assign tank_cap_code        = tank_code_q;
	assign filter_cap_code      = filter_code_q;

	// The ADC standby bit falling is the trigger for tuning.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			adc_section_standby_mask_prev_q <= 1'b1;
		end else begin
			adc_section_standby_mask_prev_q <= section_standby_mask_q[AB];
		end
	end

	assign start_ev = adc_section_standby_mask_prev_q & ~section_standby_mask_q[AB]
		& (state_q == tune_pkg::ST_IDLE);
	assign start_tank   = start_ev & flags_q[TB];
	assign start_filter = (start_ev & ~flags_q[TB] & flags_q[FB])
		| (tank_done & flags_q[FB]);

	// A missing resonance during tank tuning or a low sync input freezes the step.
	assign halted = ~sync_q[5]
		| (~sync_q[4] & (state_q == tune_pkg::ST_TANK));
	assign step_done = (state_q != tune_pkg::ST_IDLE) & ~halted
		& (settle_q == SETTLE_LAST);
	assign tank_done   = step_done & (state_q == tune_pkg::ST_TANK)
		& (idx_q == 4'h0);
	assign filter_done = step_done & (state_q == tune_pkg::ST_FILTER)
		& (idx_q == 4'h0);

	// Tune flags; a host write in the same cycle wins over the hardware clear.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= 2'h0;
		end else if (wr_tune) begin
			flags_q <= {link_wdata[TB], link_wdata[FB]};
		end else begin
			if (tank_done) begin
				flags_q[TB] <= 1'b0;
			end
			if (filter_done) begin
				flags_q[FB] <= 1'b0;
			end
		end
	end

	// Engine state and bit index; clearing a flag aborts its stage.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= tune_pkg::ST_IDLE;
			idx_q   <= 4'h0;
		end else begin
			case (state_q)
			tune_pkg::ST_IDLE: begin
				if (start_tank) begin
					state_q <= tune_pkg::ST_TANK;
					idx_q   <= 4'(TW - 1);
				end else if (start_filter) begin
					state_q <= tune_pkg::ST_FILTER;
					idx_q   <= 4'(FW - 1);
				end
			end
			tune_pkg::ST_TANK: begin
				if (!flags_q[TB]) begin
					state_q <= tune_pkg::ST_IDLE;
				end else if (start_filter) begin
					state_q <= tune_pkg::ST_FILTER;
					idx_q   <= 4'(FW - 1);
				end else if (tank_done) begin
					state_q <= tune_pkg::ST_IDLE;
				end else if (step_done) begin
					idx_q <= idx_q - 4'h1;
				end
			end
			tune_pkg::ST_FILTER: begin
				if (!flags_q[FB] || filter_done) begin
					state_q <= tune_pkg::ST_IDLE;
				end else if (step_done) begin
					idx_q <= idx_q - 4'h1;
				end
			end
			default: state_q <= tune_pkg::ST_IDLE;
			endcase
		end
	end

	// Settling count per trial bit; it holds while the step is frozen.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			settle_q <= 16'h0000;
		end else if (state_q == tune_pkg::ST_IDLE || step_done) begin
			settle_q <= 16'h0000;
		end else if (!halted) begin
			settle_q <= settle_q + 16'h0001;
		end
	end

	// Successive approximation of both capacitor codes; host may write them
	// while idle. The discrete-time stage follows the clock by itself and has
	// no code here. Standby never touches the codes.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tank_code_q   <= '0;
			filter_code_q <= '0;
		end else if (state_q == tune_pkg::ST_IDLE && !start_ev) begin
			if (wr_ev && link_addr == tune_pkg::ADDR_COARSE) begin
				tank_code_q[TW-1:6] <= link_wdata[2:0];
			end
			if (wr_ev && link_addr == tune_pkg::ADDR_FINE) begin
				tank_code_q[5:0] <= link_wdata[5:0];
			end
			if (wr_ev && link_addr == tune_pkg::ADDR_FILTER) begin
				filter_code_q <= link_wdata;
			end
		end else begin
			if (start_tank) begin
				tank_code_q <= TW'(1) << (TW - 1);
			end else if (step_done && state_q == tune_pkg::ST_TANK) begin
				tank_code_q[idx_q] <= sync_q[2];
				if (idx_q != 4'h0) begin
					tank_code_q[idx_q - 4'h1] <= 1'b1;
				end
			end
			if (start_filter) begin
				filter_code_q <= FW'(1) << (FW - 1);
			end else if (step_done && state_q == tune_pkg::ST_FILTER) begin
				filter_code_q[idx_q[2:0]] <= sync_q[3];
				if (idx_q != 4'h0) begin
					filter_code_q[idx_q[2:0] - 3'h1] <= 1'b1;
				end
			end
		end
	end

	// Busy flag and sample port gate; no samples while tuning.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tune_busy          <= 1'b0;
			sample_port_enable <= 1'b0;
		end else begin
			tune_busy          <= state_q != tune_pkg::ST_IDLE;
			sample_port_enable <= ~section_standby_mask_q[AB] & ~start_ev
				& (state_q == tune_pkg::ST_IDLE);
		end
	end

	// Clock output at half the sample clock, gated by standby and tristate.
	assign clock_output_pin_en = ~section_standby_mask_q[AB] & ~clock_output_pin_ctrl_q[tune_pkg::CLOCK_OUTPUT_PIN_TRI_BIT];
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_q               <= 1'b0;
			clock_output_pin_oe <= 1'b0;
		end else begin
			div_q               <= clock_output_pin_en & ~div_q;
			clock_output_pin_oe <= clock_output_pin_en;
		end
	end
	assign clock_output_pin = div_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	chk_tank_first: assert property (start_ev && flags_q == 2'h3
		|=> state_q == tune_pkg::ST_TANK ##0 tank_code_q[TW-1])
		else $error("tank stage did not come first");
	chk_tank_start: assert property (start_tank
		|=> state_q == tune_pkg::ST_TANK && tune_busy == 1'b0 ##1 tune_busy)
		else $error("tank tuning did not start");
	chk_filter_start: assert property (start_ev && flags_q == 2'h1
		|=> state_q == tune_pkg::ST_FILTER)
		else $error("filter tuning did not start");
	chk_tank_clear: assert property (tank_done && !wr_tune
		|=> !flags_q[TB] && $past(settle_q) == SETTLE_LAST)
		else $error("tank flag not cleared on completion");
	chk_filter_clear: assert property (filter_done && !wr_tune
		|=> !flags_q[FB] && state_q == tune_pkg::ST_IDLE)
		else $error("filter flag not cleared on completion");
	chk_no_samples: assert property (state_q != tune_pkg::ST_IDLE
		|=> !sample_port_enable)
		else $error("sample port enabled during tuning");
	chk_halt_hold: assert property (tune_busy && halted && !wr_ev
		&& state_q != tune_pkg::ST_IDLE
		|=> $stable(settle_q) && $stable(flags_q) && $stable(idx_q))
		else $error("tuning advanced while stalled");
	chk_clock_output_pin_gate: assert property (!clock_output_pin_en
		|=> !clock_output_pin_oe ##0 !clock_output_pin)
		else $error("clock output driven while gated");
	chk_codes_keep: assert property (state_q == tune_pkg::ST_IDLE
		&& !wr_ev && !start_ev |=> $stable(tank_code_q)
		&& $stable(filter_code_q))
		else $error("codes changed without tuning or write");
	chk_hold_write: assert property (wr_tune
		|=> flags_q == {$past(link_wdata[TB]), $past(link_wdata[FB])})
		else $error("tune control write lost");

	cov_both_tuned: cover property (tank_done ##[1:1000] filter_done);
	cov_stalled: cover property (tune_busy && halted);
	cov_abort: cover property (wr_tune && tune_busy);
	cov_filter_only: cover property (start_ev && flags_q == 2'h1);

endmodule

// [tune_pkg.sv]
package tune_pkg;

	// Register addresses on the serial control port.
	localparam logic [6:0] ADDR_STANDBY  = 7'h00;
	localparam logic [6:0] ADDR_CLOCK_OUTPUT_PIN   = 7'h18;
	localparam logic [6:0] ADDR_TUNE     = 7'h1C;
	localparam logic [6:0] ADDR_COARSE   = 7'h1D;
	localparam logic [6:0] ADDR_FINE     = 7'h1E;
	localparam logic [6:0] ADDR_FILTER   = 7'h1F;
	localparam logic [6:0] ADDR_DAC_CTRL = 7'h38;
	localparam logic [6:0] ADDR_DAC_VAL  = 7'h39;
	localparam logic [6:0] ADDR_TEST     = 7'h3E;

	// Reset values.
	localparam logic [7:0] STANDBY_RST = 8'hFF;
	localparam logic [7:0] ZERO_RST    = 8'h00;

	// Field positions and widths.
	localparam int TANK_FLAG_BIT   = 1;
	localparam int FILTER_FLAG_BIT = 0;
	localparam int ADC_SECTION_STANDBY_MASK_BIT    = 0;
	localparam int CLOCK_OUTPUT_PIN_TRI_BIT  = 0;
	localparam int COARSE_W        = 3;
	localparam int FINE_W          = 6;
	localparam int TANK_W          = COARSE_W + FINE_W;
	localparam int FILTER_W        = 8;

	// Serial frame: read flag, 7-bit address, 8 turnaround, 8 data bits.
	localparam logic [4:0] ADDR_LAST  = 5'h07;
	localparam logic [4:0] TURN_LAST  = 5'h0F;
	localparam logic [4:0] DATA_LAST  = 5'h17;
	localparam logic [4:0] FRAME_BITS = 5'h18;

	// Timing.
	localparam int MCLK_HZ        = 50_000_000;
	localparam int CYC_PER_US     = MCLK_HZ / 1_000_000;
	localparam int STEP_SETTLE_US = 100;
	localparam int STEP_SETTLE_CYC = STEP_SETTLE_US * CYC_PER_US;
	localparam int TUNE_BUDGET_US = 6000;
	localparam int TUNE_BUDGET_CYC = TUNE_BUDGET_US * CYC_PER_US;

	// Tuning engine states.
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_TANK   = 2'b01,
		ST_FILTER = 2'b10
	} tune_state_t;

endpackage

// [flop_sync.sv]
`timescale 1ns/1ps
module flop_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Levels in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// Two flip-flops per bit; the first feeds only the second.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				meta_q[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_q[i] <= d[i];
				q[i]      <= meta_q[i];
			end
		end
	end

endmodule

// [serial_ctrl_link.sv]
`timescale 1ns/1ps
module serial_ctrl_link (
	// Link pins
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	input  wire logic       rst_b,
	// Core side, bundled with the toggles
	output logic [6:0]      addr_q,
	output logic            rd_q,
	output logic [7:0]      wdata_q,
	output logic            addr_tgl_q,
	output logic            data_tgl_q,
	input  wire logic [7:0] rd_data
);

	logic       frame_rst_b;
	logic [4:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] out_q;

	// The frame's own enable ends every frame-local state.
	assign frame_rst_b = rst_b & ~cs_n;
	assign sdo = out_q[7];

	// Bit counter and input shifter.
	always_ff @(posedge sclk or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			cnt_q <= 5'h00;
			sh_q  <= 8'h00;
		end else begin
			sh_q <= {sh_q[6:0], sdi};
			if (cnt_q != tune_pkg::FRAME_BITS) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// Captured words survive the frame; toggles tell the core.
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q     <= 7'h00;
			rd_q       <= 1'b0;
			wdata_q    <= 8'h00;
			addr_tgl_q <= 1'b0;
			data_tgl_q <= 1'b0;
		end else if (!cs_n && cnt_q == tune_pkg::ADDR_LAST) begin
			{rd_q, addr_q} <= {sh_q[6:0], sdi};
			addr_tgl_q     <= ~addr_tgl_q;
		end else if (!cs_n && cnt_q == tune_pkg::DATA_LAST) begin
			wdata_q    <= {sh_q[6:0], sdi};
			data_tgl_q <= ~data_tgl_q;
		end
	end

	// Read data is loaded after the turnaround, by which time it is settled.
	always_ff @(posedge sclk or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			out_q  <= 8'h00;
			sdo_oe <= 1'b0;
		end else if (cnt_q == tune_pkg::TURN_LAST) begin
			out_q  <= rd_data;
			sdo_oe <= rd_q;
		end else begin
			out_q <= {out_q[6:0], 1'b0};
			if (cnt_q == tune_pkg::FRAME_BITS) begin
				sdo_oe <= 1'b0;
			end
		end
	end

endmodule

// [host_ctrl_model.sv]
`timescale 1ns/1ps
// Host controller on the serial control port; frames are run by a task.
module host_ctrl_model (
	// Serial control port
	output logic      serial_clk,
	output logic      serial_enable_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out,
	input  wire logic serial_data_out_oe
);
	// Outside frames the link clock stands still and the enable is high.
	initial begin
		serial_clk = 1'b0;
		serial_enable_n = 1'b1;
		serial_data_in = 1'b0;
	end

	// One 24-bit frame at a 64 ns period, MSB first; undriven reads are X.
	task automatic xfer(input logic rd, input logic [6:0] addr,
		input logic [7:0] wdata, output logic [7:0] rdata);
		logic [23:0] frame;
		frame = {rd, addr, 8'h00, wdata};
		rdata = 8'h00;
		serial_enable_n = 1'b0;
		for (int i = 0; i < 24; i++) begin
			serial_data_in = frame[23 - i];
			#31;
			if (i >= 16) begin
				rdata[23 - i] = serial_data_out_oe ? serial_data_out : 1'bx;
			end
			#1 serial_clk = 1'b1;
			#32 serial_clk = 1'b0;
		end
		#32 serial_enable_n = 1'b1;
		// A released data line shows the inverse of its last value.
		serial_data_in = ~serial_data_in;
		#64;
	endtask
endmodule

// [resonator_tune_sequencer_tb_top.sv]
`timescale 1ns/1ps
module resonator_tune_sequencer_tb_top;
	// One row: address, value written, value expected back.
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} reg_row_t;

	logic       mclk;
	logic       rst_b;
	logic       serial_clk;
	logic       serial_enable_n;
	logic       serial_data_in;
	logic       serial_data_out;
	logic       serial_data_out_oe;
	logic       tank_freq_high;
	logic       filter_freq_high;
	logic       tank_osc_ok;
	logic       sync_input_n;
	logic [7:0] section_standby_mask;
	logic [8:0] tank_cap_code;
	logic [7:0] filter_cap_code;
	logic       dac_manual_en;
	logic [7:0] dac_manual_value;
	logic [7:0] converter_test_bits;
	logic       tune_busy;
	logic       clock_output_pin;
	logic       clock_output_pin_oe;
	logic       sample_port_enable;
	logic       watch_order;
	logic       clk_seen;
	int         cyc;
	int         n_errors;
	int         total_checks;
	reg_row_t   rows [9] = '{
		'{7'h3E, 8'h47, 8'h47}, '{7'h38, 8'h01, 8'h01},
		'{7'h39, 8'h0F, 8'h0F}, '{7'h1D, 8'h05, 8'h05},
		'{7'h1E, 8'h2A, 8'h2A}, '{7'h1F, 8'hA5, 8'hA5},
		'{7'h1D, 8'hFF, 8'h07}, '{7'h1E, 8'hFF, 8'h3F},
		'{7'h55, 8'h12, 8'h00}};

	// Sample clock, 50 MHz.
	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	resonator_tune_sequencer #(.STEP_SETTLE_CYC(8)) dut_u (
		.mclk(mclk), .rst_b(rst_b),
		.serial_clk(serial_clk), .serial_enable_n(serial_enable_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe),
		.tank_freq_high(tank_freq_high), .filter_freq_high(filter_freq_high),
		.tank_osc_ok(tank_osc_ok), .sync_input_n(sync_input_n),
		.section_standby_mask(section_standby_mask),
		.tank_cap_code(tank_cap_code), .filter_cap_code(filter_cap_code),
		.dac_manual_en(dac_manual_en), .dac_manual_value(dac_manual_value),
		.converter_test_bits(converter_test_bits), .tune_busy(tune_busy),
		.clock_output_pin(clock_output_pin),
		.clock_output_pin_oe(clock_output_pin_oe),
		.sample_port_enable(sample_port_enable));

	host_ctrl_model host_u (
		.serial_clk(serial_clk), .serial_enable_n(serial_enable_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe));

	// Counts and reports one comparison.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register access; the pause lets the write cross into mclk.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host_u.xfer(1'b0, a, d, unused);
		repeat (6) @(posedge mclk);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		host_u.xfer(1'b1, a, 8'h00, d);
		repeat (6) @(posedge mclk);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		check({8'h00, d}, {8'h00, e});
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Arms the flags with the converter in standby, then releases it.
	task automatic tune(input logic [7:0] flags);
		wr(tune_pkg::ADDR_STANDBY, 8'h45);
		wr(tune_pkg::ADDR_TUNE, flags);
		wr(tune_pkg::ADDR_STANDBY, 8'h44);
	endtask

	// Polls the flags until zero; running out of polls ends the run.
	task automatic poll_clear();
		logic [7:0] d;
		int t0;
		t0 = cyc;
		d = 8'hFF;
		for (int k = 0; k < 40 && d !== 8'h00; k++) begin
			rd(tune_pkg::ADDR_TUNE, d);
		end
		if (d !== 8'h00) begin
			$display("timeout at %0t waiting for flags to clear", $time);
			n_errors++;
			end_sim();
		end else begin
			check({15'h0, (cyc - t0) < tune_pkg::TUNE_BUDGET_CYC},
				16'h1);
		end
	endtask

	// Watches the sample port gate and the order of the two stages.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (tune_busy === 1'b1) begin
			check({15'h0, sample_port_enable}, 16'h0);
		end
		if (watch_order && filter_cap_code !== 8'h00) begin
			watch_order = 1'b0;
			check({7'h0, tank_cap_code}, 16'h0);
		end
	end

	// Main sequence: reset, register rows, then the tuning cases.
	initial begin
		rst_b = 1'b0;
		tank_freq_high = 1'b0;
		filter_freq_high = 1'b1;
		tank_osc_ok = 1'b1;
		sync_input_n = 1'b1;
		watch_order = 1'b0;
		cyc = 0;
		n_errors = 0;
		total_checks = 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		check({8'h0, section_standby_mask}, 16'h00FF);
		check({15'h0, clock_output_pin_oe}, 16'h0);
		rd_chk(tune_pkg::ADDR_STANDBY, tune_pkg::STANDBY_RST);
		rd_chk(tune_pkg::ADDR_TUNE, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].rdata);
		end
		check({7'h0, tank_cap_code}, 16'h01FF);
		check({8'h0, dac_manual_value}, 16'h000F);
		check({8'h0, converter_test_bits}, 16'h0047);
		check({15'h0, dac_manual_en}, 16'h1);
		// Both stages: the tank settles low, the filter settles high.
		wr(tune_pkg::ADDR_FILTER, 8'h00);
		watch_order = 1'b1;
		tune(8'h03);
		poll_clear();
		check({7'h0, tank_cap_code}, 16'h0);
		rd_chk(tune_pkg::ADDR_COARSE, 8'h00);
		rd_chk(tune_pkg::ADDR_FINE, 8'h00);
		rd_chk(tune_pkg::ADDR_FILTER, 8'hFF);
		// Host winds the sequence down and checks the clock output gate.
		wr(tune_pkg::ADDR_DAC_CTRL, 8'h00);
		wr(tune_pkg::ADDR_TEST, 8'h00);
		wr(tune_pkg::ADDR_STANDBY, 8'h40);
		check({15'h0, dac_manual_en}, 16'h0);
		check({8'h0, converter_test_bits}, 16'h0000);
		check({15'h0, sample_port_enable}, 16'h1);
		check({15'h0, clock_output_pin_oe}, 16'h1);
		// The enabled clock output changes level on every sample clock.
		clk_seen = clock_output_pin;
		@(posedge mclk);
		check({15'h0, clock_output_pin ^ clk_seen}, 16'h1);
		wr(tune_pkg::ADDR_CLOCK_OUTPUT_PIN, 8'h01);
		check({15'h0, clock_output_pin_oe}, 16'h0);
		check({15'h0, clock_output_pin}, 16'h0);
		// Standby in and out with no flags keeps the codes.
		wr(tune_pkg::ADDR_STANDBY, 8'h41);
		wr(tune_pkg::ADDR_STANDBY, 8'h40);
		check({15'h0, tune_busy}, 16'h0);
		rd_chk(tune_pkg::ADDR_FILTER, 8'hFF);
		// Sync held low stalls the tank stage; the host aborts it.
		@(posedge mclk) begin
			sync_input_n <= 1'b0;
			tank_freq_high <= 1'b1;
		end
		tune(8'h02);
		repeat (200) @(posedge mclk);
		rd_chk(tune_pkg::ADDR_TUNE, 8'h02);
		wr(tune_pkg::ADDR_TUNE, 8'h00);
		rd_chk(tune_pkg::ADDR_TUNE, 8'h00);
		// A tank that does not resonate stalls the retry until it does.
		@(posedge mclk) begin
			sync_input_n <= 1'b1;
			tank_osc_ok <= 1'b0;
		end
		tune(8'h02);
		repeat (200) @(posedge mclk);
		rd_chk(tune_pkg::ADDR_TUNE, 8'h02);
		@(posedge mclk) tank_osc_ok <= 1'b1;
		poll_clear();
		check({7'h0, tank_cap_code}, 16'h01FF);
		check({8'h0, filter_cap_code}, 16'h00FF);
		// Filter stage alone, settling low; the tank code stays.
		@(posedge mclk) filter_freq_high <= 1'b0;
		tune(8'h01);
		poll_clear();
		check({8'h0, filter_cap_code}, 16'h0);
		check({7'h0, tank_cap_code}, 16'h01FF);
		// A reset in mid-run returns the registers to their defaults.
		@(posedge mclk) rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		check({8'h0, section_standby_mask}, 16'h00FF);
		check({7'h0, tank_cap_code}, 16'h0);
		check({15'h0, clock_output_pin_oe}, 16'h0);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_chk(tune_pkg::ADDR_TUNE, 8'h00);
		rd_chk(tune_pkg::ADDR_STANDBY, tune_pkg::STANDBY_RST);
		end_sim();
	end
endmodule
